// ### timer16_core.v
// 16-bit timer/counter with clock-source select and Avalon-MM slave
`timescale 1ns/10ps
`include "timer16_defines.vh"
module timer16_core
(
   // Clock and reset
   input wire clock,
   input wire srst,
   // Avalon-MM slave
   input wire [`ADDR_W-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   // Pins and comparator
   input wire ext_count_pin,
   input wire capture_pin,
   input wire comparator_out,
   output reg compare_out_a,
   output reg compare_out_b,
   output reg compare_oe_a,
   output reg compare_oe_b,
   // Status and events
   output reg timer_tick,
   output reg irq_pending,
   output reg at_bottom,
   output reg at_max,
   output reg at_top
);
   // Registers.
   // Compare values are double buffered: software writes the buffer,
   // and the active copy is loaded only at a TOP tick.
   reg [15:0] count_value_r;       // Counter
   reg [15:0] compare_value_a_r;   // Active compare A
   reg [15:0] compare_value_b_r;   // Active compare B
   reg [15:0] cmp_a_buf_r;         // Buffered compare A
   reg [15:0] cmp_b_buf_r;         // Buffered compare B
   reg [15:0] capture_value_r;     // Captured count
   reg [7:0] timer_control_a_r;    // Top select and output enables
   reg [7:0] timer_control_b_r;    // Clock select and capture options
   reg [3:0] timer_flag_reg_r;     // Sticky event flags
   reg [3:0] timer_mask_reg_r;     // Event masks
   reg ack_r;                      // Access acknowledged this cycle
   reg cap_src_d_r;                // Previous capture source select

   // Combinational
   reg tick_nxt;
   reg [15:0] top_val;
   reg [15:0] count_nxt;
   reg [3:0] flag_set;
   wire [3:0] tap_pulse;
   wire ext_rise;
   wire ext_fall;
   wire cap_rise;
   wire cap_fall;
   wire cap_in;
   wire cap_event;
   wire [2:0] clock_select_field;
   wire [1:0] top_sel;
   wire presc_clear;
   wire wr_hit;
   wire rd_hit;
   wire [31:0] wmask;
   wire cnt_wr;
   wire at_top_now;
   wire cap_enabled;

   assign clock_select_field =
      timer_control_b_r[`CB_CS_HI:`CB_CS_LO];
   assign top_sel = timer_control_a_r[`CA_TOPSEL_HI:`CA_TOPSEL_LO];

   // One wait cycle per access keeps the handshake simple and fixed.
   // First cycle of a request: waitrequest high, ack_r set at its end.
   // Second cycle: waitrequest low, the master samples it at the edge.
   // A write lands on that same edge, so it takes effect exactly when
   // the master is told it is done; reads fetch in the first cycle so
   // that readdata already stands when waitrequest is sampled low.
   // Trade-off: every access costs two cycles, even back to back.
   assign waitrequest = (read | write) & ~ack_r;
   assign wr_hit = write & ack_r;
   assign rd_hit = read & ~ack_r;
   assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign presc_clear = wr_hit & (address == `OFS_PRESC) &
                        writedata[`PR_RESET];
   assign cnt_wr = wr_hit & (address == `OFS_COUNT);

   // The prescaler never stops with the timer, so a divided source
   // starts on whatever phase the divider holds; software that needs
   // a known phase clears it first through the reset register.
   // Shared prescaler, free running
   prescaler u_prescaler
   (
      .clock(clock),
      .srst(srst),
      .presc_clear(presc_clear),
      .tap_pulse(tap_pulse)
   );

   // Count pin path: latch, sync, edge detect, never filtered.
   // The edge pulse comes straight from the second stage, so the count
   // moves two and a half to three and a half cycles after the pin,
   // depending on where in the clock period the pin edge lands.
   // Pin ticks bypass the prescaler entirely.
   pin_sync_edge u_ext_sync
   (
      .clock(clock),
      .srst(srst),
      .pin_in(ext_count_pin),
      .filter_en(1'b0),
      .rise_pulse(ext_rise),
      .fall_pulse(ext_fall)
   );

   // Capture source: pin or comparator, optional filter.
   // Switching the source can look like an edge to the detector;
   // software should clear the capture flag after changing it.
   // The filter adds five cycles of delay before the edge detector.
   assign cap_in = timer_control_b_r[`CB_CAP_SRC] ? comparator_out :
                   capture_pin;
   pin_sync_edge u_cap_sync
   (
      .clock(clock),
      .srst(srst),
      .pin_in(cap_in),
      .filter_en(timer_control_b_r[`CB_NOISE_EN]),
      .rise_pulse(cap_rise),
      .fall_pulse(cap_fall)
   );

   // Capture disabled while capture register defines TOP
   assign cap_enabled = (top_sel != `TOP_CAPT);
   assign cap_event = cap_enabled &
      (timer_control_b_r[`CB_CAP_EDGE] ? cap_rise : cap_fall);

   // Clock select logic.
   // Codes six and seven take pin edges undivided; codes one to five are
   // internal and code zero stops, so a stray pin edge can never reach the count.
   always @*
   begin
      case (clock_select_field)
         `CS_STOP: tick_nxt = 1'b0;
         `CS_DIV1: tick_nxt = 1'b1;
         `CS_DIV8: tick_nxt = tap_pulse[0];
         `CS_DIV64: tick_nxt = tap_pulse[1];
         `CS_DIV256: tick_nxt = tap_pulse[2];
         `CS_DIV1024: tick_nxt = tap_pulse[3];
         `CS_EXT_FALL: tick_nxt = ext_fall;
         `CS_EXT_RISE: tick_nxt = ext_rise;
         default: tick_nxt = 1'b0;
      endcase
   end

   // TOP source selection.
   // Fixed TOP is the 8-bit maximum; compare A or capture may replace it.
   always @*
   begin
      case (top_sel)
         `TOP_CMPA: top_val = compare_value_a_r;
         `TOP_CAPT: top_val = capture_value_r;
         default: top_val = `CNT_MAX;
      endcase
   end
   assign at_top_now = (count_value_r == top_val);

   // Next count: CPU write first, then wrap at TOP, else increment.
   // The write wins so that software can load the count at any time,
   // running or stopped, without racing a tick.
   always @*
   begin
      count_nxt = count_value_r;
      if (cnt_wr)
         count_nxt = (count_value_r & ~wmask[15:0]) |
                     (writedata[15:0] & wmask[15:0]);
      else if (tick_nxt)
      begin
         if (at_top_now)
            count_nxt = `CNT_BOTTOM;
         else
            count_nxt = count_value_r + `CNT_ONE;
      end
   end

   // Event flags raised this cycle.
   // Match flags follow the compare while it holds, not only on a tick,
   // so a stopped counter parked on a compare value keeps it set.
   always @*
   begin
      flag_set = 4'h0;
      flag_set[`FL_OVF] = tick_nxt & at_top_now & ~cnt_wr;
      flag_set[`FL_MATCH_A] = (count_value_r == compare_value_a_r) &
                              (top_sel != `TOP_CMPA);
      flag_set[`FL_MATCH_B] = (count_value_r == compare_value_b_r);
      flag_set[`FL_CAPT] = cap_event;
   end

   // Counter, capture, compare buffers and handshake
   always @(posedge clock)
   begin
      if (srst)
      begin
         count_value_r <= `CNT_BOTTOM;
         compare_value_a_r <= 16'hFFFF;
         compare_value_b_r <= 16'hFFFF;
         cmp_a_buf_r <= 16'hFFFF;
         cmp_b_buf_r <= 16'hFFFF;
         capture_value_r <= `CNT_BOTTOM;
         ack_r <= 1'b0;
         timer_tick <= 1'b0;
         cap_src_d_r <= 1'b0;
      end
      else
      begin
         ack_r <= (read | write) & ~ack_r;
         timer_tick <= tick_nxt;
         cap_src_d_r <= timer_control_b_r[`CB_CAP_SRC];
         count_value_r <= count_nxt;
         // Buffered compares load at TOP so PWM never glitches
         if (tick_nxt & at_top_now)
         begin
            compare_value_a_r <= cmp_a_buf_r;
            compare_value_b_r <= cmp_b_buf_r;
         end
         if (wr_hit & (address == `OFS_CMP_A))
            cmp_a_buf_r <= (cmp_a_buf_r & ~wmask[15:0]) |
                           (writedata[15:0] & wmask[15:0]);
         if (wr_hit & (address == `OFS_CMP_B))
            cmp_b_buf_r <= (cmp_b_buf_r & ~wmask[15:0]) |
                           (writedata[15:0] & wmask[15:0]);
         // Capture register: event copy, or TOP write when it is TOP
         if (cap_event)
            capture_value_r <= count_value_r;
         else if (wr_hit & (address == `OFS_CAPTURE) & ~cap_enabled)
            capture_value_r <= (capture_value_r & ~wmask[15:0]) |
                               (writedata[15:0] & wmask[15:0]);
      end
   end

   // Control, flag and mask registers.
   // Control writes take lane zero only; the upper lanes have no bits.
   always @(posedge clock)
   begin
      if (srst)
      begin
         timer_control_a_r <= 8'h00;
         timer_control_b_r <= 8'h00;
         timer_flag_reg_r <= 4'h0;
         timer_mask_reg_r <= 4'h0;
      end
      else
      begin
         if (wr_hit & (address == `OFS_CTRL_A) & byteenable[0])
            timer_control_a_r <= writedata[7:0];
         if (wr_hit & (address == `OFS_CTRL_B) & byteenable[0])
            timer_control_b_r <= writedata[7:0];
         if (wr_hit & (address == `OFS_MASK) & byteenable[0])
            timer_mask_reg_r <= writedata[3:0];
         // Write one clears; a new event in the same cycle wins
         if (wr_hit & (address == `OFS_FLAGS) & byteenable[0])
            timer_flag_reg_r <= (timer_flag_reg_r & ~writedata[3:0]) |
                                flag_set;
         else
            timer_flag_reg_r <= timer_flag_reg_r | flag_set;
      end
   end

   // Status outputs and compare pins.
   // Limit flags come from the next count so that they line up with
   // the count register rather than lagging it by a cycle.
   always @(posedge clock)
   begin
      if (srst)
      begin
         at_bottom <= 1'b0;
         at_max <= 1'b0;
         at_top <= 1'b0;
         irq_pending <= 1'b0;
         compare_out_a <= 1'b0;
         compare_out_b <= 1'b0;
         compare_oe_a <= 1'b0;
         compare_oe_b <= 1'b0;
      end
      else
      begin
         at_bottom <= (count_nxt == `CNT_BOTTOM);
         at_max <= (count_nxt == `CNT_MAX);
         at_top <= (count_nxt == top_val);
         irq_pending <= |(timer_flag_reg_r & timer_mask_reg_r);
         // Toggle on match; compare A gives up its pin when it is TOP
         if (flag_set[`FL_MATCH_A] & tick_nxt)
            compare_out_a <= ~compare_out_a;
         if (flag_set[`FL_MATCH_B] & tick_nxt)
            compare_out_b <= ~compare_out_b;
         compare_oe_a <= timer_control_a_r[`CA_OUTA_EN] &
                         (top_sel != `TOP_CMPA);
         compare_oe_b <= timer_control_a_r[`CA_OUTB_EN];
      end
   end

   // Read mux, registered for one wait cycle.
   // Capturing in the first cycle keeps readdata steady through the
   // edge at which the master samples waitrequest low.
   always @(posedge clock)
   begin
      if (srst)
         readdata <= 32'h00000000;
      else if (rd_hit)
      begin
         case (address)
            `OFS_COUNT: readdata <= {16'h0000, count_value_r};
            `OFS_CMP_A: readdata <= {16'h0000, cmp_a_buf_r};
            `OFS_CMP_B: readdata <= {16'h0000, cmp_b_buf_r};
            `OFS_CAPTURE: readdata <= {16'h0000, capture_value_r};
            `OFS_CTRL_A: readdata <= {24'h000000, timer_control_a_r};
            `OFS_CTRL_B: readdata <= {24'h000000, timer_control_b_r};
            `OFS_FLAGS: readdata <= {28'h0000000, timer_flag_reg_r};
            `OFS_MASK: readdata <= {28'h0000000, timer_mask_reg_r};
            `OFS_STATUS: readdata <= {29'h00000000, at_top, at_max,
                                      at_bottom};
            default: readdata <= 32'h00000000;
         endcase
      end
   end
endmodule // timer16_core

// ### timer16_defines.vh
// Register offsets, field positions and constants for the 16-bit timer
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH
// Word addresses on the Avalon-MM bus (byte address / 4)
`define ADDR_W 4
`define OFS_COUNT 4'h0
`define OFS_CMP_A 4'h1
`define OFS_CMP_B 4'h2
`define OFS_CAPTURE 4'h3
`define OFS_CTRL_A 4'h4
`define OFS_CTRL_B 4'h5
`define OFS_FLAGS 4'h6
`define OFS_MASK 4'h7
`define OFS_PRESC 4'h8
`define OFS_STATUS 4'h9
// timer_control_a fields
`define CA_TOPSEL_LO 0
`define CA_TOPSEL_HI 1
`define CA_OUTA_EN 2
`define CA_OUTB_EN 3
// timer_control_b fields
`define CB_CS_LO 0
`define CB_CS_HI 2
`define CB_CAP_EDGE 3
`define CB_NOISE_EN 4
`define CB_CAP_SRC 5
// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
// TOP selection codes
`define TOP_MAX 2'h0
`define TOP_CMPA 2'h1
`define TOP_CAPT 2'h2
// Flag bit positions (flag and mask registers share them)
`define FL_OVF 0
`define FL_MATCH_A 1
`define FL_MATCH_B 2
`define FL_CAPT 3
// Prescaler control bit
`define PR_RESET 0
// Count values
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'h00FF
`define CNT_ONE 16'h0001
// Prescaler width and tap positions (divide by 2^(tap+1))
`define PRE_W 10
`define TAP_8 2
`define TAP_64 5
`define TAP_256 7
`define TAP_1024 9
// Noise filter depth
`define NF_DEPTH 4
`endif

// ### pin_sync_edge.v
// Pin synchronizer with optional noise filter and edge detector
`timescale 1ns/10ps
`include "timer16_defines.vh"
module pin_sync_edge
(
   // Clock and reset
   input wire clock,
   input wire srst,
   // Pin and options
   input wire pin_in,
   input wire filter_en,
   // Edge pulses
   output wire rise_pulse,
   output wire fall_pulse
);
   reg latch_r;                  // Transparent-high latch model
   reg s1_r;                     // First stage, read only by s2
   reg s2_r;                     // Second stage
   reg s3_r;                     // Third stage
   reg level_r;                  // Accepted level
   reg [`NF_DEPTH-1:0] hist_r;   // Filter history
   reg level_nxt;

   // Latch open while clock high; holds through the low phase.
   // Non-blocking so the first stage, at the rising edge, takes the
   // value held since the falling edge and never races the latch.
   always @(clock or pin_in)
      if (clock)
         latch_r <= pin_in;

   // Sampling registers on the rising edge
   always @(posedge clock)
   begin
      if (srst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= latch_r;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Unfiltered: follow stage two at once, so a level held for one
   // sample still gives an edge and the pin latency stays bounded
   always @*
   begin
      level_nxt = level_r;
      if (filter_en)
      begin
         // All four samples equal before the level moves
         if (&hist_r)
            level_nxt = 1'b1;
         else if (~|hist_r)
            level_nxt = 1'b0;
      end
      else
         level_nxt = s2_r;
   end

   // Filter history and accepted level
   always @(posedge clock)
   begin
      if (srst)
      begin
         hist_r <= {`NF_DEPTH{1'b0}};
         level_r <= 1'b0;
      end
      else
      begin
         hist_r <= {hist_r[`NF_DEPTH-2:0], s3_r};
         level_r <= level_nxt;
      end
   end

   // One pulse per detected edge
   assign rise_pulse = level_nxt & ~level_r;
   assign fall_pulse = ~level_nxt & level_r;
endmodule // pin_sync_edge

// ### prescaler.v
// Free-running shared prescaler with four taps
`timescale 1ns/10ps
`include "timer16_defines.vh"
module prescaler
(
   // Clock and reset
   input wire clock,
   input wire srst,
   // Software reset of the divider
   input wire presc_clear,
   // One-cycle tap pulses: /8, /64, /256, /1024
   output wire [3:0] tap_pulse
);
   reg [`PRE_W-1:0] div_r;   // Free-running count
   wire [`PRE_W-1:0] div_nxt;
   wire [3:0] tap_idx_all;

   assign div_nxt = div_r + {{(`PRE_W-1){1'b0}}, 1'b1};

   // Runs regardless of clock select; cleared only by reset request
   always @(posedge clock)
   begin
      if (srst || presc_clear)
         div_r <= {`PRE_W{1'b0}};
      else
         div_r <= div_nxt;
   end

   // Pulse when the low bits up to the tap are all ones
   assign tap_pulse[0] = &div_r[`TAP_8:0];
   assign tap_pulse[1] = &div_r[`TAP_64:0];
   assign tap_pulse[2] = &div_r[`TAP_256:0];
   assign tap_pulse[3] = &div_r[`TAP_1024:0];
endmodule // prescaler

// ### timer16_core_monitor.sv
// Port-level checks for the 16-bit timer clock-source front end
`timescale 1ns/10ps
`include "timer16_defines.vh"
module timer16_core_monitor
(
   // Clock and reset
   input wire clock,
   input wire srst,
   // Register bus
   input wire [`ADDR_W-1:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   // Pins
   input wire ext_count_pin,
   input wire capture_pin,
   input wire comparator_out,
   input wire compare_out_a,
   input wire compare_out_b,
   input wire compare_oe_a,
   input wire compare_oe_b,
   // Status
   input wire timer_tick,
   input wire irq_pending,
   input wire at_bottom,
   input wire at_max,
   input wire at_top
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   reg [2:0] cs_r; // Shadow of the clock select field
   reg [1:0] top_r; // Shadow of the top select field
   reg [11:0] same_r; // Cycles since the tick setup changed
   reg [11:0] gap_r; // Cycles since the last tick
   reg seen_r; // Tick seen once the setup settled
   // Write that lands at this edge
   wire done_w = write && !waitrequest && byteenable[0];
   // Any write that disturbs the tick phase
   wire cfg_w = done_w && (address == `OFS_CTRL_B ||
      (address == `OFS_PRESC && writedata[`PR_RESET]));
   // Divided source selected
   wire divd_w = cs_r >= `CS_DIV8 && cs_r <= `CS_DIV1024;
   // Divisor per select code
   function [11:0] div_of(input [2:0] c);
      case (c)
         `CS_DIV8: div_of = 12'h008;
         `CS_DIV64: div_of = 12'h040;
         `CS_DIV256: div_of = 12'h100;
         default: div_of = 12'h400;
      endcase
   endfunction
   // Shadow fields from completed writes
   always @(posedge clock)
   begin
      if (srst)
         cs_r <= 3'h0;
      else if (done_w && address == `OFS_CTRL_B)
         cs_r <= writedata[2:0];
      if (srst)
         top_r <= 2'h0;
      else if (done_w && address == `OFS_CTRL_A)
         top_r <= writedata[1:0];
   end
   // Tick spacing; early ticks may still come from the old setup
   always @(posedge clock)
   begin
      if (srst || cfg_w)
      begin
         same_r <= 12'h000;
         gap_r <= 12'h000;
         seen_r <= 1'b0;
      end
      else
      begin
         same_r <= (same_r == 12'hFFF) ? same_r : same_r + 12'h001;
         gap_r <= timer_tick ? 12'h000 : gap_r + 12'h001;
         seen_r <= seen_r || (timer_tick && same_r > 12'h006);
      end
   end
   // Settled pin edge of the selected polarity
   sequence pin_edge_s;
      same_r > 12'h006 && ((cs_r == `CS_EXT_RISE && $rose(ext_count_pin))
         || (cs_r == `CS_EXT_FALL && $fell(ext_count_pin)));
   endsequence
   // Completed count read while stopped
   sequence count_read_s;
      read && !waitrequest && address == `OFS_COUNT &&
         cs_r == `CS_STOP && same_r > 12'h006;
   endsequence
   wait_one_a: assert property (
      (read || write) && !$past(read || write) |-> waitrequest ##1
      !waitrequest) else $error("access not held off one cycle");
   unmapped_zero_a: assert property (
      read && !waitrequest && address > `OFS_STATUS |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   stop_quiet_a: assert property (
      cs_r == `CS_STOP && same_r > 12'h006 |-> !timer_tick)
      else $error("tick while stopped");
   full_rate_a: assert property (
      cs_r == `CS_DIV1 && same_r > 12'h003 |-> timer_tick)
      else $error("undivided tick missing");
   div_gap_a: assert property (
      timer_tick && seen_r && divd_w |-> gap_r + 12'h001 == div_of(cs_r))
      else $error("divided tick spacing wrong");
   first_tick_a: assert property (
      divd_w && !seen_r |-> gap_r <= div_of(cs_r) + 12'h003)
      else $error("first divided tick late");
   pin_latency_a: assert property (
      pin_edge_s |-> ##[2:5] timer_tick) else $error("pin tick late");
   limits_a: assert property (
      count_read_s |-> at_bottom == (readdata[15:0] == `CNT_BOTTOM) &&
      at_max == (readdata[15:0] == `CNT_MAX)) else $error("limit flags");
   top_oe_a: assert property (
      top_r == `TOP_CMPA && $past(top_r) == `TOP_CMPA |-> !compare_oe_a)
      else $error("output A enabled while it sets TOP");
endmodule // timer16_core_monitor
bind timer16_core timer16_core_monitor mon (.clock(clock), .srst(srst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
   .capture_pin(capture_pin), .comparator_out(comparator_out),
   .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
   .compare_oe_a(compare_oe_a), .compare_oe_b(compare_oe_b),
   .timer_tick(timer_tick), .irq_pending(irq_pending),
   .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

// ### count_source.sv
// External count-clock source that drives the count pin
`timescale 1ns/10ps
module count_source
(
   // Count pin
   output logic ext_count_pin
);
   // Idles low so enabling the pin input sees no stray edge
   initial ext_count_pin = 1'b0;
   // Sends n pulses; half periods are kept above one system cycle
   task automatic pulses(input int n, input int half_ns);
      repeat (n)
      begin
         #(half_ns) ext_count_pin = 1'b1;
         #(half_ns) ext_count_pin = 1'b0;
      end
      #(half_ns);
   endtask
endmodule // count_source

// ### test_timer16_clock_source_select.sv
// Self-checking bench for the 16-bit timer clock-source front end
`timescale 1ns/10ps
`include "timer16_defines.vh"
`define CHECK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module test_timer16_clock_source_select;
   logic clock = 1'b0; // System clock
   logic srst = 1'b1; // Held for 20 cycles
   logic [3:0] address = 4'h0; // Bus request
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hF; // Full words only
   wire [31:0] readdata;
   wire waitrequest;
   wire ext_count_pin; // Driven by the source model
   logic capture_pin = 1'b0; // Capture inputs
   logic comparator_out = 1'b0;
   wire oe_a;
   wire oe_b; // Compare pins and enables
   wire out_a;
   wire out_b;
   wire timer_tick;
   wire irq_pending;
   wire at_bottom;
   wire at_max;
   int n_errors = 0;
   int n_compared = 0;
   int div_tab[6] = '{0, 1, 8, 64, 256, 1024}; // Divisor per select
   // 20 MHz clock
   always #25 clock = ~clock;
   timer16_core uut (.clock(clock), .srst(srst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
      .capture_pin(capture_pin), .comparator_out(comparator_out),
      .compare_out_a(out_a), .compare_out_b(out_b), .compare_oe_a(oe_a),
      .compare_oe_b(oe_b), .timer_tick(timer_tick),
      .irq_pending(irq_pending),
      .at_bottom(at_bottom), .at_max(at_max), .at_top());
   count_source src (.ext_count_pin(ext_count_pin));
   // Waits for the edge that samples waitrequest low
   task automatic bus_wait;
      do
         @(posedge clock);
      while (waitrequest !== 1'b0);
   endtask
   // Register write, held until accepted
   task automatic bus_write(input [3:0] a, input [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      bus_wait();
      write <= 1'b0;
   endtask
   // Register read compared with an expected word
   task automatic expect_reg(input [3:0] a, input [31:0] e, string what);
      @(posedge clock);
      address <= a;
      read <= 1'b1;
      bus_wait();
      `CHECK(what, e, readdata)
      read <= 1'b0;
   endtask
   // Cycles until the next tick, bounded
   task automatic to_tick(output int k);
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (timer_tick !== 1'b1 && k < 2000);
   endtask
   // Prints counts and the verdict, then stops
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 3100 cycles
   initial
   begin
      #(20000 * 50);
      n_errors++;
      $display("ERROR watchdog expected end seen hang");
      finish_test();
   end
   // Main sequence
   initial
   begin
      int n;
      int m;
      int w;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      expect_reg(`OFS_CMP_A, 32'h0000FFFF, "cmp_a reset");
      bus_write(4'hC, 32'h00001234);
      expect_reg(4'hC, 32'h0, "unmapped");
      // Stopped counter holds and stays accessible
      bus_write(`OFS_COUNT, 32'h00001234);
      repeat (20) @(posedge clock);
      expect_reg(`OFS_COUNT, 32'h00001234, "held count");
      bus_write(`OFS_COUNT, 32'h000000FF);
      expect_reg(`OFS_STATUS, 32'h6, "status max");
      `CHECK("at_max", 1'b1, at_max)
      bus_write(`OFS_COUNT, 32'h0);
      expect_reg(`OFS_STATUS, 32'h1, "status bottom");
      `CHECK("at_bottom", 1'b1, at_bottom)
      // Tick count over a whole number of periods, each internal source
      for (int c = 1; c <= 5; c++)
      begin
         bus_write(`OFS_CTRL_B, c);
         repeat (8) @(posedge clock);
         w = (c == 1) ? 16 : 2 * div_tab[c];
         n = 0;
         repeat (w)
         begin
            @(posedge clock);
            if (timer_tick === 1'b1)
               n++;
         end
         `CHECK("ticks", w / div_tab[c], n)
      end
      // Prescaler reset gives the same first-tick distance
      bus_write(`OFS_CTRL_B, 32'h2);
      bus_write(`OFS_PRESC, 32'h1);
      to_tick(n);
      `CHECK("presc first", 1'b1, n >= 1 && n <= 9)
      repeat (3) @(posedge clock);
      bus_write(`OFS_PRESC, 32'h1);
      to_tick(m);
      `CHECK("presc align", n, m)
      // Pin counting on each polarity, never divided
      for (int p = 0; p < 2; p++)
      begin
         bus_write(`OFS_CTRL_B, 32'h0);
         bus_write(`OFS_COUNT, 32'h0);
         bus_write(`OFS_CTRL_B, p ? 32'h6 : 32'h7);
         src.pulses(5 - 2 * p, 75 + 75 * p);
         repeat (8) @(posedge clock);
         bus_write(`OFS_CTRL_B, 32'h0);
         expect_reg(`OFS_COUNT, 5 - 2 * p, "pin count");
      end
      // Compare matches, overflow, flags and masks
      bus_write(`OFS_FLAGS, 32'hF);
      bus_write(`OFS_CMP_A, 32'h5);
      bus_write(`OFS_CMP_B, 32'h7);
      bus_write(`OFS_MASK, 32'h2);
      bus_write(`OFS_COUNT, 32'h00FE);
      bus_write(`OFS_CTRL_B, 32'h1);
      repeat (20) @(posedge clock);
      bus_write(`OFS_CTRL_B, 32'h0);
      expect_reg(`OFS_FLAGS, 32'h7, "flags");
      `CHECK("irq on", 1'b1, irq_pending)
      `CHECK("out a", 1'b1, out_a)
      `CHECK("out b", 1'b1, out_b)
      bus_write(`OFS_FLAGS, 32'h2);
      expect_reg(`OFS_FLAGS, 32'h5, "flags cleared");
      `CHECK("irq masked", 1'b0, irq_pending)
      // Capture from the pin, then the comparator through the filter
      bus_write(`OFS_CTRL_B, 32'h08);
      bus_write(`OFS_FLAGS, 32'hF);
      bus_write(`OFS_COUNT, 32'h0ABC);
      capture_pin <= 1'b1;
      repeat (12) @(posedge clock);
      expect_reg(`OFS_CAPTURE, 32'h0ABC, "pin capture");
      expect_reg(`OFS_FLAGS, 32'h8, "capture flag");
      bus_write(`OFS_CTRL_B, 32'h38);
      bus_write(`OFS_COUNT, 32'h0456);
      comparator_out <= 1'b1;
      repeat (2) @(posedge clock);
      comparator_out <= 1'b0;
      repeat (12) @(posedge clock);
      expect_reg(`OFS_CAPTURE, 32'h0ABC, "glitch filtered");
      comparator_out <= 1'b1;
      repeat (12) @(posedge clock);
      expect_reg(`OFS_CAPTURE, 32'h0456, "comp capture");
      bus_write(`OFS_CAPTURE, 32'h5555);
      expect_reg(`OFS_CAPTURE, 32'h0456, "capture refused");
      // Compare A as TOP gives up its output
      bus_write(`OFS_CTRL_A, 32'hC);
      repeat (2) @(posedge clock);
      `CHECK("oe_a on", 1'b1, oe_a)
      `CHECK("oe_b on", 1'b1, oe_b)
      bus_write(`OFS_CTRL_A, 32'h5);
      repeat (2) @(posedge clock);
      `CHECK("oe_a top", 1'b0, oe_a)
      `CHECK("oe_b off", 1'b0, oe_b)
      finish_test();
   end
endmodule // test_timer16_clock_source_select
